// [dv/nv_ctl_tb.sv]
// Self-checking testbench of the data EEPROM controller.
`timescale 1ns/1ns
`include "nv_ctl_map.svh"
module nv_ctl_tb
  import nv_ctl_pkg::*;
;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc, stb, we, ack, irq;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, din;
  logic [31:0] exp_q[$];
  logic [7:0]  d0, d1, q;
  int          mismatches = 0;
  int          compares = 0;
  integer      seed = 32'hf1cc_3a74;
  logic [7:0]  lone [3] = '{8'h01, 8'h04, 8'h20};

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  nv_ctl #(.T_ER0_CYC(20), .T_WR0_CYC(10), .T_ER1_CYC(25), .T_WR1_CYC(15)) i_nv_ctl (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(din), .wb_ack_o(ack), .nv_irq(irq));
  nv_fw_model i_nv_fw_model (
    .clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(dat),
    .din(din), .ack(ack));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  task cmp_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word

  task cmp_irq(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_irq

  // Read data is compared with the oldest note whenever a noted read is acknowledged.
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
      cmp_word(din, exp_q.pop_front());
  end

  task wr(input logic [7:0] a, input logic [7:0] d);
    i_nv_fw_model.acc(1'b1, a, d, q);
  endtask : wr

  // The note is queued on an idle edge so it never meets an earlier ack.
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    exp_q.push_back({24'h00_0000, e});
    i_nv_fw_model.acc(1'b0, a, 8'h00, q);
  endtask : rd

  task wait_clr(input logic [7:0] m);
    do i_nv_fw_model.acc(1'b0, `NV_OFS_CTL, 8'h00, q); while ((q & m) != 8'h00);
  endtask : wait_clr

  // Byte read with the high address bit set, at the given low address.
  task fetch(input logic [7:0] lo, input logic [7:0] e);
    wr(`NV_OFS_CTL, 8'h02);
    wr(`NV_OFS_ADDR_LO, lo);
    wr(`NV_OFS_ADDR_HI, 8'h01);
    wr(`NV_OFS_CTL, 8'h03);
    wait_clr(8'h01);
    rd(`NV_OFS_BYTE, e);
    rd(`NV_OFS_BYTE, e);
  endtask : fetch

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    d0 = $random(seed);
    d1 = $random(seed);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(`NV_OFS_CTL, `NV_CTL_RST);
    rd(8'h14, 8'h00);
    // Start bits without their arm bit do nothing.
    foreach (lone[i]) begin
      wr(`NV_OFS_CTL, lone[i]);
      rd(`NV_OFS_CTL, 8'h00);
    end
    // Arm and start split by another write is refused.
    wr(`NV_OFS_CTL, 8'h08);
    wr(`NV_OFS_ADDR_LO, 8'h0E);
    wr(`NV_OFS_CTL, 8'h0C);
    rd(`NV_OFS_CTL, 8'h08);
    wr(`NV_OFS_STAT, 8'h06);
    // Byte writes with both time selections.
    for (int i = 0; i < 2; i++) begin
      wr(`NV_OFS_CTL, 8'h00);
      wr(`NV_OFS_ADDR_LO, 8'h0E + i);
      wr(`NV_OFS_ADDR_HI, 8'h01);
      wr(`NV_OFS_BYTE, i ? d1 : d0);
      wr(`NV_OFS_CTL, i ? 8'h88 : 8'h08);
      wr(`NV_OFS_CTL, i ? 8'h8C : 8'h0C);
      wait_clr(8'h0C);
      rd(`NV_OFS_CTL, i ? 8'h80 : 8'h00);
      rd(`NV_OFS_STAT, 8'h07);
      cmp_irq(irq, 1'b1);
      wr(`NV_OFS_STAT, 8'h07);
      repeat (2) @(posedge clk);
      cmp_irq(irq, 1'b0);
    end
    fetch(8'h0E, d0);
    // Page read saturates at the last offset of the page.
    wr(`NV_OFS_CTL, 8'h12);
    for (int k = 0; k < 3; k++) begin
      wr(`NV_OFS_CTL, 8'h13);
      wait_clr(8'h01);
      rd(`NV_OFS_BYTE, k ? d1 : d0);
      rd(`NV_OFS_ADDR_LO, 8'h0F);
    end
    rd(`NV_OFS_ADDR_HI, 8'h01);
    // A tag dropped by disarming is forgotten; the later tag is erased.
    wr(`NV_OFS_CTL, 8'h10);
    wr(`NV_OFS_BYTE, 8'hA5);
    wr(`NV_OFS_CTL, 8'h50);
    wr(`NV_OFS_CTL, 8'h10);
    wr(`NV_OFS_ADDR_LO, 8'h0E);
    wr(`NV_OFS_BYTE, 8'h5A);
    rd(`NV_OFS_ADDR_LO, 8'h0F);
    wr(`NV_OFS_CTL, 8'h50);
    wr(`NV_OFS_CTL, 8'h70);
    wait_clr(8'h60);
    rd(`NV_OFS_CTL, 8'h10);
    rd(`NV_OFS_STAT, 8'h07);
    fetch(8'h0E, 8'h00);
    fetch(8'h0F, d1);
    complete_run();
  end

  // Watchdog cuts a hang short.
  initial begin
    repeat (50000) @(posedge clk);
    mismatches++;
    complete_run();
  end
endmodule : nv_ctl_tb

// [dv/nv_fw_model.sv]
// Bus master model of the firmware that drives the EEPROM controller.
`timescale 1ns/1ns
// ----------------------------------------
// Firmware bus master
// ----------------------------------------
module nv_fw_model (
  input  wire logic        clk,  // System clock.
  output logic             cyc,  // Cycle request.
  output logic             stb,  // Strobe.
  output logic             we,   // Write when high.
  output logic      [7:0]  adr,  // Byte address.
  output logic      [3:0]  sel,  // Byte selects.
  output logic      [31:0] dat,  // Write data.
  input  wire logic [31:0] din,  // Read data.
  input  wire logic        ack   // Acknowledge.
);
  // Bus is idle with scrambled address and data at time zero.
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we  = 1'b0;
    adr = 8'h55;
    sel = 4'hf;
    dat = 32'h5a5a_5a5a;
  end

  // One classic cycle; each call is one firmware instruction, so one register access at a time.
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h00_0000, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = din[7:0];
    // Released lines stop showing the last value.
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= ~w;
    adr <= ~a;
    dat <= {24'hff_ffff, ~d};
  endtask : acc
endmodule : nv_fw_model

// [src/nv_ctl.sv]
// Data EEPROM controller with a classic Wishbone register slave.
// Notes on behaviour
// - Write cycles run only while prog_arm is set; hardware clears it after writing. A CTL write that clears it mid-write does not stop the write.
// - prog_start starts a write only when prog_arm is set; cleared at end.
// - Read cycles run only while fetch_arm is set; a CTL write that clears it mid-read does not stop the read.
// - fetch_start starts a read only when fetch_arm is set; cleared at end.
// - Byte read: load address, arm, start; byte lands in nv_byte_reg.
// - nv_byte_reg holds read data until the next read or write.
// - Page read loads data, bumps offset and clears fetch_start in the same cycle.
// - Upper five address bits are page; only lower four increment.
// - Offset saturates at 0xF with no wrap or carry.
// - Page buffer cleared at reset and when wipe_arm falls.
// - Page erase: each data write tags current address, then advances offset.
// - Erase starts only if wipe_start follows wipe_arm in the next write.
// - Erase and write are timed by an internal timer.
// - Erase end clears wipe_start then wipe_arm; erased bytes read zero.
// - Write starts only if prog_start follows prog_arm in the next write.
// - Write end clears prog_start then prog_arm.
// - A byte write erases the target byte before programming it.
// - prog_time_sel picks erase/write times 3.2/2.2 ms or 3.7/3.0 ms.
// - Erase or write end sets the done flag; gated interrupt request.
// - Page buffer holds sixteen tag bits; mode bit selects page operation.
`timescale 1ns/1ns
`include "nv_ctl_map.svh"
module nv_ctl
  import nv_ctl_pkg::*;
#(
  parameter int T_ER0_CYC = `NV_T_ER0_US * `NV_CLK_MHZ,
  parameter int T_WR0_CYC = `NV_T_WR0_US * `NV_CLK_MHZ,
  parameter int T_ER1_CYC = `NV_T_ER1_US * `NV_CLK_MHZ,
  parameter int T_WR1_CYC = `NV_T_WR1_US * `NV_CLK_MHZ
) (
  input  wire logic        clk,       // System clock, 100 MHz.
  input  wire logic        rst,       // Synchronous reset, active high.
  input  wire logic        wb_cyc_i,  // Wishbone cycle.
  input  wire logic        wb_stb_i,  // Wishbone strobe.
  input  wire logic        wb_we_i,   // Wishbone write enable.
  input  wire logic [7:0]  wb_adr_i,  // Wishbone byte address.
  input  wire logic [3:0]  wb_sel_i,  // Wishbone byte selects.
  input  wire logic [31:0] wb_dat_i,  // Wishbone write data.
  output logic      [31:0] wb_dat_o,  // Wishbone read data.
  output logic             wb_ack_o,  // Wishbone acknowledge.
  output logic             nv_irq     // Done request, gated by both enables.
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    nv_state_e   st;
    logic [7:0]  ctl;
    logic [8:0]  addr;
    logic [7:0]  data;
    logic [15:0] tag;
    logic [8:0]  wadr;
    logic [1:0]  rdcnt;
    logic [31:0] tmr;
    logic        pre;
    logic        done;
    logic        irq_en;
    logic        gie;
    logic        arm_w_last;
    logic        arm_e_last;
    logic        ack;
    logic [31:0] rdat;
  } nv_reg_s;

  nv_reg_s r_r;
  nv_reg_s r_nxt;

  logic       mem_we;
  logic [8:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic       wr_acc;
  logic       rd_acc;
  logic [7:0] wv;
  logic [3:0] ofs_inc;
  logic [8:0] pg_adr;

  assign wr_acc  = wb_cyc_i & wb_stb_i & wb_we_i & ~r_r.ack & wb_sel_i[0];
  assign rd_acc  = wb_cyc_i & wb_stb_i & ~r_r.ack;
  assign wv      = wb_dat_i[7:0];
  // Offset saturates at the page end; page bits never move.
  assign ofs_inc = (r_r.addr[3:0] == 4'hF) ? 4'hF : r_r.addr[3:0] + 4'h1;
  assign pg_adr  = {r_r.addr[8:4], r_r.wadr[3:0]};

  // ----------------------------------------------------------------
  // Cell array
  // ----------------------------------------------------------------
  nv_mem #(
    .DEPTH (512),
    .AW    (9)
  ) u_mem (
    .clk   (clk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (r_r.addr),
    .rdata (mem_rdata)
  );

  // Cell writes happen only at the end of a timed erase or program step.
  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = r_r.addr;
    mem_wdata = 8'h00;
    if (r_r.st == ST_ERASE && r_r.tmr == 32'h0000_0000) begin
      mem_we    = r_r.ctl[`NV_CTL_MODE_B] ? r_r.tag[r_r.wadr[3:0]] : 1'b1;
      mem_waddr = r_r.ctl[`NV_CTL_MODE_B] ? pg_adr : r_r.addr;
    end else if (r_r.st == ST_PROG && r_r.tmr == 32'h0000_0000) begin
      mem_we    = 1'b1;
      mem_wdata = r_r.data;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_nxt     = r_r;
    r_nxt.ack = rd_acc;
    // Register reads.
    if (rd_acc) begin
      case (wb_adr_i)
        `NV_OFS_ADDR_LO: r_nxt.rdat = {24'h00_0000, r_r.addr[7:0]};
        `NV_OFS_ADDR_HI: r_nxt.rdat = {31'h0000_0000, r_r.addr[8]};
        `NV_OFS_BYTE:    r_nxt.rdat = {24'h00_0000, r_r.data};
        `NV_OFS_CTL:     r_nxt.rdat = {24'h00_0000, r_r.ctl};
        `NV_OFS_STAT:    r_nxt.rdat = {29'h0000_0000, r_r.gie, r_r.irq_en, r_r.done};
        default:         r_nxt.rdat = 32'h0000_0000;
      endcase
    end
    // Register writes; any write ends an arm-then-start pairing window.
    if (wr_acc) begin
      r_nxt.arm_w_last = 1'b0;
      r_nxt.arm_e_last = 1'b0;
      case (wb_adr_i)
        `NV_OFS_ADDR_LO: r_nxt.addr[7:0] = wv;
        `NV_OFS_ADDR_HI: r_nxt.addr[8]   = wv[0];
        `NV_OFS_BYTE: begin
          r_nxt.data = wv;
          // Erase tagging: mark current address, then advance.
          if (r_r.ctl[`NV_CTL_MODE_B] && r_r.st == ST_IDLE) begin
            r_nxt.tag[r_r.addr[3:0]] = 1'b1;
            r_nxt.addr[3:0]          = ofs_inc;
          end
        end
        `NV_OFS_CTL: begin
          r_nxt.ctl[`NV_CTL_TSEL_B] = wv[`NV_CTL_TSEL_B];
          r_nxt.ctl[`NV_CTL_MODE_B] = wv[`NV_CTL_MODE_B];
          r_nxt.ctl[`NV_CTL_FETCH_ARM_B] = wv[`NV_CTL_FETCH_ARM_B];
          r_nxt.ctl[`NV_CTL_PROG_ARM_B] = wv[`NV_CTL_PROG_ARM_B];
          r_nxt.ctl[`NV_CTL_WIPE_ARM_B] = wv[`NV_CTL_WIPE_ARM_B];
          r_nxt.arm_w_last = wv[`NV_CTL_PROG_ARM_B] & ~r_r.ctl[`NV_CTL_PROG_ARM_B];
          r_nxt.arm_e_last = wv[`NV_CTL_WIPE_ARM_B] & ~r_r.ctl[`NV_CTL_WIPE_ARM_B];
          // Buffer cleared when wipe_arm falls, not when it rises.
          if (r_r.ctl[`NV_CTL_WIPE_ARM_B] && !wv[`NV_CTL_WIPE_ARM_B]) begin
            r_nxt.tag = 16'h0000;
          end
          if (r_r.st == ST_IDLE) begin
            // Read start needs fetch_arm already set.
            if (wv[`NV_CTL_RD_B] && r_r.ctl[`NV_CTL_FETCH_ARM_B] && wv[`NV_CTL_FETCH_ARM_B]) begin
              r_nxt.ctl[`NV_CTL_RD_B] = 1'b1;
              r_nxt.st    = ST_READ;
              r_nxt.rdcnt = 2'(`NV_RD_CYC - 1);
            end else if (wv[`NV_CTL_ER_B] && r_r.arm_e_last && wv[`NV_CTL_WIPE_ARM_B]) begin
              // Erase starts only right after wipe_arm was set.
              r_nxt.ctl[`NV_CTL_ER_B] = 1'b1;
              r_nxt.st   = ST_ERASE;
              r_nxt.pre  = 1'b0;
              r_nxt.wadr = 9'h000;
              r_nxt.tmr  = r_r.ctl[`NV_CTL_TSEL_B] ? 32'(T_ER1_CYC - 1)
                                                    : 32'(T_ER0_CYC - 1);
            end else if (wv[`NV_CTL_WR_B] && r_r.arm_w_last && wv[`NV_CTL_PROG_ARM_B]) begin
              // Write starts only right after prog_arm was set.
              r_nxt.ctl[`NV_CTL_WR_B] = 1'b1;
              r_nxt.st   = ST_ERASE;
              r_nxt.pre  = 1'b1;
              r_nxt.tmr  = r_r.ctl[`NV_CTL_TSEL_B] ? 32'(T_ER1_CYC - 1)
                                                    : 32'(T_ER0_CYC - 1);
            end
          end
        end
        `NV_OFS_STAT: begin
          r_nxt.irq_en = wv[`NV_STAT_IRQEN_B];
          r_nxt.gie    = wv[`NV_STAT_GIE_B];
          if (wv[`NV_STAT_DONE_B]) begin
            r_nxt.done = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Operation sequencer; its flag sets come last so they win over clears.
    case (r_r.st)
      ST_IDLE: ;
      ST_READ: begin
        if (r_r.rdcnt == 2'd0) begin
          r_nxt.data = mem_rdata;
          if (r_r.ctl[`NV_CTL_MODE_B]) begin
            r_nxt.addr[3:0] = ofs_inc;
          end
          r_nxt.ctl[`NV_CTL_RD_B] = 1'b0;
          r_nxt.st = ST_IDLE;
        end else begin
          r_nxt.rdcnt = r_r.rdcnt - 2'd1;
        end
      end
      ST_ERASE: begin
        // Page erase walks all sixteen slots, zeroing tagged ones.
        if (r_r.tmr != 32'h0000_0000) begin
          r_nxt.tmr = r_r.tmr - 32'h0000_0001;
        end else if (r_r.pre) begin
          r_nxt.st  = ST_PROG;
          r_nxt.tmr = r_r.ctl[`NV_CTL_TSEL_B] ? 32'(T_WR1_CYC - 1)
                                               : 32'(T_WR0_CYC - 1);
        end else if (r_r.ctl[`NV_CTL_MODE_B] && r_r.wadr[3:0] != 4'hF) begin
          r_nxt.wadr = r_r.wadr + 9'h001;
        end else begin
          r_nxt.ctl[`NV_CTL_ER_B] = 1'b0;
          r_nxt.st = ST_DONE;
        end
      end
      ST_PROG: begin
        if (r_r.tmr != 32'h0000_0000) begin
          r_nxt.tmr = r_r.tmr - 32'h0000_0001;
        end else begin
          r_nxt.ctl[`NV_CTL_WR_B] = 1'b0;
          r_nxt.st = ST_DONE;
        end
      end
      ST_DONE: begin
        // Arm bits drop one cycle after start bits.
        if (r_r.ctl[`NV_CTL_WIPE_ARM_B]) begin
          r_nxt.tag = 16'h0000;
        end
        r_nxt.ctl[`NV_CTL_PROG_ARM_B] = 1'b0;
        r_nxt.ctl[`NV_CTL_WIPE_ARM_B] = 1'b0;
        r_nxt.done = 1'b1;
        r_nxt.st   = ST_IDLE;
      end
      default: r_nxt.st = ST_IDLE;
    endcase
  end

  // State register with synchronous reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      r_r     <= '0;
      r_r.st  <= ST_IDLE;
      r_r.ctl <= `NV_CTL_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign wb_ack_o = r_r.ack;
  assign wb_dat_o = r_r.rdat;
  assign nv_irq   = r_r.done & r_r.irq_en & r_r.gie;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_wr_needs_arm;
    @(posedge clk) disable iff (rst)
      (r_r.st == ST_PROG) |-> r_r.ctl[`NV_CTL_PROG_ARM_B];
  endproperty
  a_wr_needs_arm: assert property (p_wr_needs_arm) else $error("write without prog_arm");

  property p_wr_start;
    @(posedge clk) disable iff (rst)
      $rose(r_r.ctl[`NV_CTL_WR_B]) |-> $past(r_r.arm_w_last);
  endproperty
  a_wr_start: assert property (p_wr_start) else $error("write start not paired");

  property p_rd_arm;
    @(posedge clk) disable iff (rst)
      (r_r.st == ST_READ) |-> r_r.ctl[`NV_CTL_FETCH_ARM_B];
  endproperty
  a_rd_arm: assert property (p_rd_arm) else $error("read without fetch_arm");

  property p_rd_done;
    @(posedge clk) disable iff (rst)
      $rose(r_r.ctl[`NV_CTL_RD_B]) |-> ##3 !r_r.ctl[`NV_CTL_RD_B];
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read did not end in 3 cycles");

  property p_ofs_sat;
    @(posedge clk) disable iff (rst)
      ($past(r_r.addr[3:0]) == 4'hF && r_r.st != ST_IDLE) |-> r_r.addr[3:0] == 4'hF;
  endproperty
  a_ofs_sat: assert property (p_ofs_sat) else $error("offset wrapped");

  property p_page_fixed;
    @(posedge clk) disable iff (rst)
      (r_r.st == ST_READ) |=> r_r.addr[8:4] == $past(r_r.addr[8:4]);
  endproperty
  a_page_fixed: assert property (p_page_fixed) else $error("page bits changed");

  property p_arm_after;
    @(posedge clk) disable iff (rst)
      (r_r.st == ST_DONE) |=> !r_r.ctl[`NV_CTL_PROG_ARM_B] && !r_r.ctl[`NV_CTL_WIPE_ARM_B] && r_r.done;
  endproperty
  a_arm_after: assert property (p_arm_after) else $error("arm bits not cleared");

  property p_er_start;
    @(posedge clk) disable iff (rst)
      $rose(r_r.ctl[`NV_CTL_ER_B]) |-> $past(r_r.arm_e_last);
  endproperty
  a_er_start: assert property (p_er_start) else $error("erase start not paired");

  property p_rd_start;
    @(posedge clk) disable iff (rst)
      $rose(r_r.ctl[`NV_CTL_RD_B]) |-> $past(r_r.ctl[`NV_CTL_FETCH_ARM_B]);
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("read start without arm");

  property p_wr_arm_start;
    @(posedge clk) disable iff (rst)
      $rose(r_r.ctl[`NV_CTL_WR_B]) |-> r_r.ctl[`NV_CTL_PROG_ARM_B];
  endproperty
  a_wr_arm_start: assert property (p_wr_arm_start) else $error("write start without arm");

  property p_er_clr_order;
    @(posedge clk) disable iff (rst)
      $fell(r_r.ctl[`NV_CTL_ER_B]) |-> r_r.ctl[`NV_CTL_WIPE_ARM_B] ##1 !r_r.ctl[`NV_CTL_WIPE_ARM_B];
  endproperty
  a_er_clr_order: assert property (p_er_clr_order) else $error("erase clear order");

  property p_wr_clr_order;
    @(posedge clk) disable iff (rst)
      $fell(r_r.ctl[`NV_CTL_WR_B]) |-> r_r.ctl[`NV_CTL_PROG_ARM_B] ##1 !r_r.ctl[`NV_CTL_PROG_ARM_B];
  endproperty
  a_wr_clr_order: assert property (p_wr_clr_order) else $error("write clear order");

  property p_byte_hold;
    @(posedge clk) disable iff (rst)
      (r_r.st == ST_IDLE && !wr_acc) |=> $stable(r_r.data);
  endproperty
  a_byte_hold: assert property (p_byte_hold) else $error("byte register changed");

  property p_pg_inc;
    @(posedge clk) disable iff (rst)
      (r_r.st == ST_READ && r_r.rdcnt == 2'd0 && r_r.ctl[`NV_CTL_MODE_B]
       && r_r.addr[3:0] != 4'hF) |=> r_r.addr[3:0] == $past(r_r.addr[3:0]) + 4'h1;
  endproperty
  a_pg_inc: assert property (p_pg_inc) else $error("page offset did not advance");
endmodule : nv_ctl

// [src/nv_ctl_map.svh]
// Register offsets, field positions, reset values and timing counts of the data EEPROM controller.
`ifndef NV_CTL_MAP_SVH
`define NV_CTL_MAP_SVH
`define NV_OFS_ADDR_LO   8'h00
`define NV_OFS_ADDR_HI   8'h04
`define NV_OFS_BYTE      8'h08
`define NV_OFS_CTL       8'h0C
`define NV_OFS_STAT      8'h10
`define NV_CTL_RD_B      0
`define NV_CTL_FETCH_ARM_B    1
`define NV_CTL_WR_B      2
`define NV_CTL_PROG_ARM_B    3
`define NV_CTL_MODE_B    4
`define NV_CTL_ER_B      5
`define NV_CTL_WIPE_ARM_B    6
`define NV_CTL_TSEL_B    7
`define NV_STAT_DONE_B   0
`define NV_STAT_IRQEN_B  1
`define NV_STAT_GIE_B    2
`define NV_CTL_RST       8'h00
`define NV_CLK_MHZ       100
`define NV_T_ER0_US      3200
`define NV_T_WR0_US      2200
`define NV_T_ER1_US      3700
`define NV_T_WR1_US      3000
`define NV_RD_CYC        3
`endif

// [src/nv_ctl_pkg.sv]
// Types shared by the data EEPROM controller.
package nv_ctl_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_READ  = 3'b001,
    ST_ERASE = 3'b011,
    ST_PROG  = 3'b010,
    ST_DONE  = 3'b110
  } nv_state_e;
  typedef logic [8:0] nv_addr_t;
endpackage : nv_ctl_pkg

// [src/nv_mem.sv]
// EEPROM cell array with registered read data.
`timescale 1ns/1ns
module nv_mem #(
  parameter int DEPTH = 512,
  parameter int AW    = 9
) (
  input  wire logic          clk,    // System clock.
  input  wire logic          we,     // Write strobe.
  input  wire logic [AW-1:0] waddr,  // Write address.
  input  wire logic [7:0]    wdata,  // Write data.
  input  wire logic [AW-1:0] raddr,  // Read address.
  output logic      [7:0]    rdata   // Registered read data.
);
  logic [7:0] cells [DEPTH];

  // Array write and registered read; the array has no reset, as a real cell has none.
  always_ff @(posedge clk) begin
    if (we) begin
      cells[waddr] <= wdata;
    end
    rdata <= cells[raddr];
  end
endmodule : nv_mem
